// ==== meas_pkg.sv ====
// package for the measurement, energy and event block
// assumes fixed-point settings: currents in units of 0.01, power in 0.01 MW/Mvar, mA in units of 0.01 mA
package meas_pkg;
	// register offsets (word indices on the plain register port)
	localparam logic [7:0] ADDR_SCALE = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h01;
	localparam logic [7:0] ADDR_PWEIGHT = 8'h02;
	localparam logic [7:0] ADDR_ACT_LIM = 8'h03;
	localparam logic [7:0] ADDR_REA_LIM = 8'h04;
	localparam logic [7:0] ADDR_ACT_PWR = 8'h05;
	localparam logic [7:0] ADDR_REA_PWR = 8'h06;
	localparam logic [7:0] ADDR_STORE = 8'h07;
	localparam logic [7:0] ADDR_IA = 8'h08;
	localparam logic [7:0] ADDR_IB = 8'h09;
	localparam logic [7:0] ADDR_IC = 8'h0A;
	localparam logic [7:0] ADDR_PVAL = 8'h0B;
	localparam logic [7:0] ADDR_QVAL = 8'h0C;
	localparam logic [7:0] ADDR_E_KWH = 8'h0D;
	localparam logic [7:0] ADDR_E_SPLIT = 8'h0E;
	localparam logic [7:0] ADDR_E_IMP_P = 8'h0F;
	localparam logic [7:0] ADDR_E_EXP_P = 8'h10;
	localparam logic [7:0] ADDR_E_IMP_Q = 8'h11;
	localparam logic [7:0] ADDR_E_EXP_Q = 8'h12;
	localparam logic [7:0] ADDR_EVT = 8'h13;
	localparam logic [7:0] ADDR_MASK0 = 8'h20;
	// ctrl field positions
	localparam int CTRL_PWR_EN = 0;
	localparam int CTRL_EN_EN = 1;
	localparam int CTRL_MODE_LO = 2;
	localparam int CTRL_POL = 4;
	// reset / factory values, ranges and fixed constants
	localparam logic [19:0] SCALE_RST = 20'h04E20;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic POL_RST = 1'b1;
	localparam logic [16:0] WEIGHT_RST = 17'h00064;
	localparam logic [19:0] SCALE_MAX = 20'hF4240;
	localparam logic [16:0] WEIGHT_MIN = 17'h00001;
	localparam logic [16:0] WEIGHT_MAX = 17'h186A0;
	localparam logic signed [15:0] MA_MIN = -16'sd2000;
	localparam logic signed [15:0] MA_MAX = 16'sd2000;
	localparam logic [10:0] MASK_WIDE_MAX = 11'h7FF;
	localparam logic [10:0] MASK_NARROW_MAX = 11'h00F;
	localparam logic [10:0] MASK_RST_NARROW = 11'h003;
	localparam logic [10:0] MASK_RST_WIDE = 11'h753;
	localparam int NUM_CHAN = 14;
	localparam logic [39:0] KWH_WRAP = 40'h003B9ACA00;
	localparam logic [39:0] CENTI_PER_KWH = 40'h0000000064;
	// integration: 1 ms tick at 125 MHz; 0.01 MW is 10 kW, and 1 ms is 1/3600000 h, so divide |p|*10 by 3600000
	localparam int CLK_MHZ = 125;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
	localparam logic [39:0] INT_DIV = 40'h000036EE80;
	// mode codes
	typedef enum logic [1:0] {
		MODE_GENERAL = 2'h0,
		MODE_PULSE_NOLED = 2'h1,
		MODE_PULSE_LED = 2'h2
	} input_mode_t;
endpackage

// ==== power_scaler.sv ====
// linear interpolation of one mA transducer channel to signed power
// assumes settings stable while a result is taken; combinational core, registered result
`timescale 1ns/1ps
`default_nettype none
module power_scaler (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// settings and input
	input wire logic enable,
	input wire logic signed [15:0] ma_in,
	input wire logic signed [15:0] ma_low,
	input wire logic signed [15:0] ma_high,
	input wire logic signed [15:0] pwr_low,
	input wire logic signed [15:0] pwr_high,
	// result
	output logic signed [15:0] power
);
	logic signed [15:0] power_q, power_d;
	logic signed [16:0] x, span;
	logic signed [16:0] dp;
	logic signed [33:0] prod;
	logic signed [33:0] quo;
	// clamp outside the limit window, else interpolate
	always_comb begin
		x = 17'(ma_in) - 17'(ma_low);
		span = 17'(ma_high) - 17'(ma_low);
		dp = 17'(pwr_high) - 17'(pwr_low);
		prod = 34'(x) * 34'(dp);
		quo = (span == 17'sh0) ? 34'sh0 : prod / 34'(span);
		if (!enable) begin
			power_d = 16'sh0;
		end else if (span == 17'sh0 || ma_in <= ma_low) begin
			power_d = pwr_low;
		end else if (ma_in >= ma_high) begin
			power_d = pwr_high;
		end else begin
			power_d = 16'(34'(pwr_low) + quo);
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			power_q <= 16'sh0;
		end else begin
			power_q <= power_d;
		end
	end
	assign power = power_q;
endmodule
`default_nettype wire

// ==== meas_core.sv ====
// measurement block: current scaling, power scaling, energy, event masking
// assumes ma and current samples synchronous to clock; pulse pin asynchronous
// Notes on behaviour
// - phase currents reported in kA using rated primary current setting.
// - current scale 0.00 to 10000.00, factory value 200.00.
// - power measured only when power enable set; enable resets to 0.
// - transducer inputs accepted across -20 to +20 mA.
// - per channel low/high mA limits and power at each derive power.
// - signed active and reactive power readable as separate values.
// - energy accumulates only when energy enable set; defaults to 0.
// - channel 7 mode 0 general input, 1 counter no LED, 2 with LED.
// - pulse polarity 0 counts falling edges, 1 (default) rising.
// - each pulse adds weight 0.01 to 1000 kWh, default 1.
// - energy as kWh/MWh/GWh three-digit parts or one nine-digit kWh.
// - enabled energy without pulse mode integrates measured power.
// - integrating keeps active and reactive energy both directions.
// - event carries ms timestamp, channel 0 to 13, code.
// - per-channel writable mask; events 1-11 reported only if their bit set, 50 and up always.
// - written settings except masks take effect only after store command of 1.
// - mask limited 0-15 for channel 0 and 4-13, 0-2047 for 1-3.
`timescale 1ns/1ps
`default_nettype none
module meas_core #(
	parameter int TICK = meas_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// analog samples (same clock domain)
	input wire logic [15:0] phase_raw_a,
	input wire logic [15:0] phase_raw_b,
	input wire logic [15:0] phase_raw_c,
	input wire logic signed [15:0] active_ma,
	input wire logic signed [15:0] reactive_ma,
	// channel 7 pin
	input wire logic ch7_pin,
	output logic pulse_led,
	output logic ch7_status,
	// events from other channels
	input wire logic evt_valid,
	input wire logic [3:0] evt_chan,
	input wire logic [5:0] evt_code,
	output logic evt_out_valid,
	output logic [35:0] evt_out
);
	// working and committed settings
	logic [19:0] scale_w_q, scale_w_d, scale_q, scale_d;
	logic [5:0] ctrl_w_q, ctrl_w_d, ctrl_q, ctrl_d;
	logic [16:0] weight_w_q, weight_w_d, weight_q, weight_d;
	logic [63:0] alim_w_q, alim_w_d, alim_q, alim_d;
	logic [63:0] rlim_w_q, rlim_w_d, rlim_q, rlim_d;
	logic [10:0] mask_q [meas_pkg::NUM_CHAN];
	logic [10:0] mask_d [meas_pkg::NUM_CHAN];
	logic [31:0] rdata_q, rdata_d;
	logic signed [15:0] pval, qval;
	logic signed [15:0] act_ma_c, rea_ma_c;
	logic sync1_q, sync2_q, prev_q;
	logic [39:0] ekwh_q, ekwh_d, frac_q, frac_d;
	logic [39:0] eacc_q [4];
	logic [39:0] eacc_d [4];
	logic [39:0] efrac_q [4];
	logic [39:0] efrac_d [4];
	logic [31:0] tick_q, tick_d, ms_q, ms_d;
	logic evt_v_q, evt_v_d;
	logic [35:0] evt_q, evt_d;
	logic pulse_edge, pulse_mode, en_energy, en_power;

	// clamp a limit write into range; clipping a setting beats rejecting the whole write
	function automatic logic [10:0] mask_limit(input logic [3:0] ch, input logic [31:0] v);
		logic [10:0] top;
		top = (ch >= 4'h1 && ch <= 4'h3) ? meas_pkg::MASK_WIDE_MAX : meas_pkg::MASK_NARROW_MAX;
		mask_limit = (v > 32'(top)) ? top : v[10:0];
	endfunction
	function automatic logic [10:0] mask_default(input int ch);
		mask_default = (ch >= 1 && ch <= 3) ? meas_pkg::MASK_RST_WIDE : meas_pkg::MASK_RST_NARROW;
	endfunction
	function automatic logic signed [15:0] ma_clip(input logic signed [15:0] v);
		ma_clip = (v < meas_pkg::MA_MIN) ? meas_pkg::MA_MIN : (v > meas_pkg::MA_MAX) ? meas_pkg::MA_MAX : v;
	endfunction
	// phase current kA in 0.001 units: raw is per-unit of rated *1000
	function automatic logic [31:0] to_ka(input logic [15:0] raw, input logic [19:0] sc);
		logic [47:0] p;
		p = 48'(raw) * 48'(sc);
		to_ka = 32'(p / 48'h186A0);
	endfunction

	assign en_power = ctrl_q[meas_pkg::CTRL_PWR_EN];
	assign en_energy = ctrl_q[meas_pkg::CTRL_EN_EN];
	assign pulse_mode = ctrl_q[meas_pkg::CTRL_MODE_LO +: 2] == meas_pkg::MODE_PULSE_NOLED
		|| ctrl_q[meas_pkg::CTRL_MODE_LO +: 2] == meas_pkg::MODE_PULSE_LED;
	assign act_ma_c = ma_clip(active_ma);
	assign rea_ma_c = ma_clip(reactive_ma);

	// two power channels share one scaler design
	power_scaler u_act (
		.clock(clock), .rst_n(rst_n), .enable(en_power), .ma_in(act_ma_c),
		.ma_low(alim_q[15:0]), .ma_high(alim_q[31:16]),
		.pwr_low(alim_q[47:32]), .pwr_high(alim_q[63:48]), .power(pval)
	);
	power_scaler u_rea (
		.clock(clock), .rst_n(rst_n), .enable(en_power), .ma_in(rea_ma_c),
		.ma_low(rlim_q[15:0]), .ma_high(rlim_q[31:16]),
		.pwr_low(rlim_q[47:32]), .pwr_high(rlim_q[63:48]), .power(qval)
	);

	// settings: writes go to working copy, store commits; masks are written directly
	always_comb begin
		scale_w_d = scale_w_q;
		ctrl_w_d = ctrl_w_q;
		weight_w_d = weight_w_q;
		alim_w_d = alim_w_q;
		rlim_w_d = rlim_w_q;
		scale_d = scale_q;
		ctrl_d = ctrl_q;
		weight_d = weight_q;
		alim_d = alim_q;
		rlim_d = rlim_q;
		mask_d = mask_q;
		if (wr) begin
			case (addr)
				meas_pkg::ADDR_SCALE: scale_w_d = (wdata[19:0] > meas_pkg::SCALE_MAX) ? meas_pkg::SCALE_MAX : wdata[19:0];
				meas_pkg::ADDR_CTRL: begin
					ctrl_w_d = wdata[5:0];
					if (wdata[3:2] == 2'h3) begin
						ctrl_w_d[3:2] = meas_pkg::MODE_RST;
					end
				end
				meas_pkg::ADDR_PWEIGHT: begin
					weight_w_d = wdata[16:0];
					if (wdata[16:0] < meas_pkg::WEIGHT_MIN) weight_w_d = meas_pkg::WEIGHT_MIN;
					if (wdata[16:0] > meas_pkg::WEIGHT_MAX) weight_w_d = meas_pkg::WEIGHT_MAX;
				end
				meas_pkg::ADDR_ACT_LIM: alim_w_d[31:0] = {ma_clip(wdata[31:16]), ma_clip(wdata[15:0])};
				meas_pkg::ADDR_REA_LIM: rlim_w_d[31:0] = {ma_clip(wdata[31:16]), ma_clip(wdata[15:0])};
				meas_pkg::ADDR_ACT_PWR: alim_w_d[63:32] = wdata;
				meas_pkg::ADDR_REA_PWR: rlim_w_d[63:32] = wdata;
				meas_pkg::ADDR_STORE: begin
					if (wdata == 32'h00000001) begin
						scale_d = scale_w_q;
						ctrl_d = ctrl_w_q;
						weight_d = weight_w_q;
						alim_d = alim_w_q;
						rlim_d = rlim_w_q;
					end
				end
				default: begin
					if (addr >= meas_pkg::ADDR_MASK0 && addr < meas_pkg::ADDR_MASK0 + 8'(meas_pkg::NUM_CHAN)) begin
						mask_d[4'(addr - meas_pkg::ADDR_MASK0)] = mask_limit(4'(addr - meas_pkg::ADDR_MASK0), wdata);
					end
				end
			endcase
		end
	end

	// channel 7 synchroniser and edge pick by polarity
	assign pulse_edge = ctrl_q[meas_pkg::CTRL_POL] ? (sync2_q && !prev_q) : (!sync2_q && prev_q);

	// energy: pulse counting or power integration
	always_comb begin
		logic [39:0] add;
		logic [39:0] p_abs;
		add = 40'h0;
		p_abs = 40'h0;
		ekwh_d = ekwh_q;
		frac_d = frac_q;
		eacc_d = eacc_q;
		efrac_d = efrac_q;
		tick_d = (tick_q == 32'(TICK - 1)) ? 32'h0 : tick_q + 32'h1;
		ms_d = (tick_q == 32'(TICK - 1)) ? ms_q + 32'h1 : ms_q;
		if (en_energy && pulse_mode && pulse_edge) begin
			add = frac_q + 40'(weight_q);
			ekwh_d = ekwh_q + add / meas_pkg::CENTI_PER_KWH;
			frac_d = add % meas_pkg::CENTI_PER_KWH;
		end else if (en_energy && !pulse_mode && tick_q == 32'(TICK - 1)) begin
			for (int i = 0; i < 4; i++) begin
				p_abs = (i < 2) ? 40'(pval[15] ? -pval : pval) : 40'(qval[15] ? -qval : qval);
				if ((i % 2 == 0) == !((i < 2) ? pval[15] : qval[15])) begin
					add = efrac_q[i] + p_abs * 40'h000000000A;
					eacc_d[i] = eacc_q[i] + add / meas_pkg::INT_DIV;
					efrac_d[i] = add % meas_pkg::INT_DIV;
					if (eacc_d[i] >= meas_pkg::KWH_WRAP) eacc_d[i] = eacc_d[i] - meas_pkg::KWH_WRAP;
				end
			end
			ekwh_d = eacc_d[0];
		end
		if (ekwh_d >= meas_pkg::KWH_WRAP) ekwh_d = ekwh_d - meas_pkg::KWH_WRAP;
	end

	// event formatting with per-channel mask
	always_comb begin
		evt_v_d = 1'b0;
		evt_d = evt_q;
		if (evt_valid && evt_chan < 4'(meas_pkg::NUM_CHAN)) begin
			if (evt_code >= 6'd50 || (evt_code >= 6'd1 && evt_code <= 6'd11
					&& mask_q[evt_chan][4'(evt_code - 6'd1)])) begin
				evt_v_d = 1'b1;
				evt_d = {ms_q[25:0], evt_chan, evt_code};
			end
		end
	end

	// read mux; data stands one cycle after the strobe
	always_comb begin
		logic [39:0] e;
		e = ekwh_q;
		rdata_d = 32'h0;
		if (rd) begin
			case (addr)
				meas_pkg::ADDR_SCALE: rdata_d = 32'(scale_w_q);
				meas_pkg::ADDR_CTRL: rdata_d = 32'(ctrl_w_q);
				meas_pkg::ADDR_PWEIGHT: rdata_d = 32'(weight_w_q);
				meas_pkg::ADDR_ACT_LIM: rdata_d = alim_w_q[31:0];
				meas_pkg::ADDR_REA_LIM: rdata_d = rlim_w_q[31:0];
				meas_pkg::ADDR_ACT_PWR: rdata_d = alim_w_q[63:32];
				meas_pkg::ADDR_REA_PWR: rdata_d = rlim_w_q[63:32];
				meas_pkg::ADDR_IA: rdata_d = to_ka(phase_raw_a, scale_q);
				meas_pkg::ADDR_IB: rdata_d = to_ka(phase_raw_b, scale_q);
				meas_pkg::ADDR_IC: rdata_d = to_ka(phase_raw_c, scale_q);
				meas_pkg::ADDR_PVAL: rdata_d = 32'(pval);
				meas_pkg::ADDR_QVAL: rdata_d = 32'(qval);
				meas_pkg::ADDR_E_KWH: rdata_d = e[31:0];
				meas_pkg::ADDR_E_SPLIT: rdata_d = {2'h0, 10'(e / 40'd1000000),
					10'(e / 40'd1000 % 40'd1000), 10'(e % 40'd1000)};
				meas_pkg::ADDR_E_IMP_P: rdata_d = eacc_q[0][31:0];
				meas_pkg::ADDR_E_EXP_P: rdata_d = eacc_q[1][31:0];
				meas_pkg::ADDR_E_IMP_Q: rdata_d = eacc_q[2][31:0];
				meas_pkg::ADDR_E_EXP_Q: rdata_d = eacc_q[3][31:0];
				meas_pkg::ADDR_EVT: rdata_d = ms_q;
				default: begin
					if (addr >= meas_pkg::ADDR_MASK0 && addr < meas_pkg::ADDR_MASK0 + 8'(meas_pkg::NUM_CHAN)) begin
						rdata_d = 32'(mask_q[4'(addr - meas_pkg::ADDR_MASK0)]);
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scale_w_q <= meas_pkg::SCALE_RST;
			scale_q <= meas_pkg::SCALE_RST;
			ctrl_w_q <= 6'h10;
			ctrl_q <= 6'h10;
			weight_w_q <= meas_pkg::WEIGHT_RST;
			weight_q <= meas_pkg::WEIGHT_RST;
			alim_w_q <= 64'h0;
			alim_q <= 64'h0;
			rlim_w_q <= 64'h0;
			rlim_q <= 64'h0;
			for (int i = 0; i < meas_pkg::NUM_CHAN; i++) mask_q[i] <= mask_default(i);
			rdata_q <= 32'h0;
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
			ekwh_q <= 40'h0;
			frac_q <= 40'h0;
			for (int i = 0; i < 4; i++) begin
				eacc_q[i] <= 40'h0;
				efrac_q[i] <= 40'h0;
			end
			tick_q <= 32'h0;
			ms_q <= 32'h0;
			evt_v_q <= 1'b0;
			evt_q <= 36'h0;
		end else begin
			scale_w_q <= scale_w_d;
			scale_q <= scale_d;
			ctrl_w_q <= ctrl_w_d;
			ctrl_q <= ctrl_d;
			weight_w_q <= weight_w_d;
			weight_q <= weight_d;
			alim_w_q <= alim_w_d;
			alim_q <= alim_d;
			rlim_w_q <= rlim_w_d;
			rlim_q <= rlim_d;
			mask_q <= mask_d;
			rdata_q <= rdata_d;
			sync1_q <= ch7_pin;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			ekwh_q <= ekwh_d;
			frac_q <= frac_d;
			eacc_q <= eacc_d;
			efrac_q <= efrac_d;
			tick_q <= tick_d;
			ms_q <= ms_d;
			evt_v_q <= evt_v_d;
			evt_q <= evt_d;
		end
	end

	assign rdata = rdata_q;
	assign evt_out_valid = evt_v_q;
	assign evt_out = evt_q;
	assign pulse_led = (ctrl_q[3:2] == meas_pkg::MODE_PULSE_LED) && sync2_q;
	assign ch7_status = !pulse_mode && sync2_q;

	AST_STORE_COMMIT: assert property (@(posedge clock) disable iff (!rst_n)
		(wr && addr == meas_pkg::ADDR_STORE && wdata == 32'h1) |=> ctrl_q == $past(ctrl_w_q)) else $error("store did not commit");
	AST_NO_STORE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
		!(wr && addr == meas_pkg::ADDR_STORE) |=> $stable(ctrl_q)) else $error("settings changed without store");
	AST_ENERGY_OFF: assert property (@(posedge clock) disable iff (!rst_n)
		!en_energy |=> $stable(ekwh_q)) else $error("energy moved while disabled");
	AST_ENERGY_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
		ekwh_q < meas_pkg::KWH_WRAP) else $error("energy beyond nine digits");
	AST_MASK_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
		mask_q[0] <= meas_pkg::MASK_NARROW_MAX && mask_q[5] <= meas_pkg::MASK_NARROW_MAX) else $error("mask over range");
	AST_EVT_MASKED: assert property (@(posedge clock) disable iff (!rst_n)
		(evt_valid && evt_code == 6'd1 && evt_chan == 4'h0 && !mask_q[0][0]) |=> !evt_out_valid) else $error("masked event sent");
	AST_PWR_OFF: assert property (@(posedge clock) disable iff (!rst_n)
		!en_power[*2] |-> pval == 16'sh0) else $error("power reported while disabled");
	AST_READ_LAT: assert property (@(posedge clock) disable iff (!rst_n)
		(rd && addr == meas_pkg::ADDR_PVAL) |=> rdata == 32'($past(pval))) else $error("power read wrong");
	AST_SCALE_MAX: assert property (@(posedge clock) disable iff (!rst_n)
		scale_q <= meas_pkg::SCALE_MAX) else $error("scale over range");
endmodule
`default_nettype wire

// ==== bus_host_model.sv ====
// far-side model: the station communicator reaching the block's settings over the register port
// assumes one clock shared with the block; reads return in the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
	// clock
	input wire logic clock,
	// register port
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [31:0] rdata
);
	// idle bus at time zero
	initial begin
		addr = 8'h00;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one-cycle write strobe; settings other than masks land in the working copy only
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		wdata <= ~d; // stale data must not be mistaken for a live write
	endtask

	// one-cycle read strobe; data taken in the following cycle only
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// commit: only the value 1 makes settings take effect
	task automatic store(input logic [31:0] v);
		bus_write(meas_pkg::ADDR_STORE, v);
	endtask

	// mask as sum of included event weights, one bit per event number
	task automatic write_mask(input int chan, input logic [10:0] incl);
		bus_write(meas_pkg::ADDR_MASK0 + 8'(chan), {21'h000000, incl});
	endtask
endmodule
`default_nettype wire

// ==== measurement_scaling_energy_events_bench.sv ====
// self-checking bench for the measurement, energy and event block
// assumes meas_core with a short tick and the host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module measurement_scaling_energy_events_bench;
	logic clock, rst_n, wr, rd, ch7_pin, pulse_led, ch7_status, evt_valid, evt_out_valid;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	logic [15:0] phase_raw_a, phase_raw_b, phase_raw_c;
	logic signed [15:0] active_ma, reactive_ma;
	logic [3:0] evt_chan;
	logic [5:0] evt_code;
	logic [35:0] evt_out;
	int failures = 0;
	int total_checks = 0;

	meas_core #(.TICK(10)) u_meas_core (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .phase_raw_a(phase_raw_a), .phase_raw_b(phase_raw_b), .phase_raw_c(phase_raw_c),
		.active_ma(active_ma), .reactive_ma(reactive_ma), .ch7_pin(ch7_pin), .pulse_led(pulse_led),
		.ch7_status(ch7_status), .evt_valid(evt_valid), .evt_chan(evt_chan), .evt_code(evt_code),
		.evt_out_valid(evt_out_valid), .evt_out(evt_out));
	bus_host_model u_bus_host_model (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

	// 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		u_bus_host_model.bus_read(a, d);
		check({4'h0, d}, {4'h0, exp});
	endtask

	task automatic end_of_test;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// analog samples come from arguments so every scenario can move them
	task automatic drive_phases(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		phase_raw_a <= a;
		phase_raw_b <= b;
		phase_raw_c <= c;
	endtask

	task automatic drive_ma(input logic signed [15:0] p, input logic signed [15:0] q);
		active_ma <= p;
		reactive_ma <= q;
	endtask

	// one pin pulse, held long enough for the synchroniser
	task automatic pin_pulse;
		@(posedge clock);
		ch7_pin <= ~ch7_pin;
		repeat (8) @(posedge clock);
		ch7_pin <= ~ch7_pin;
		repeat (8) @(posedge clock);
	endtask

	// raise one event and watch the output for four cycles
	task automatic event_try(input logic [3:0] ch, input logic [5:0] code, input logic seen_exp);
		logic seen;
		logic [9:0] low;
		seen = 1'b0;
		low = 10'h000;
		@(posedge clock);
		evt_valid <= 1'b1;
		evt_chan <= ch;
		evt_code <= code;
		@(posedge clock);
		evt_valid <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			#1;
			if (evt_out_valid === 1'b1) begin
				seen = 1'b1;
				low = evt_out[9:0];
			end
			@(posedge clock);
		end
		check({35'h0, seen}, {35'h0, seen_exp});
		if (seen_exp)
			check({26'h0, low}, {26'h0, ch, code});
	endtask

	task automatic test_reset_values;
		rchk(meas_pkg::ADDR_SCALE, 32'h00004E20);
		rchk(meas_pkg::ADDR_CTRL, 32'h00000010);
		rchk(meas_pkg::ADDR_PWEIGHT, 32'h00000064);
		rchk(meas_pkg::ADDR_MASK0, 32'h00000003);
		rchk(meas_pkg::ADDR_MASK0 + 8'h02, 32'h00000753);
		rchk(8'hFF, 32'h00000000);
		$display("test reset values done");
	endtask

	task automatic test_currents;
		drive_phases(16'h03E8, 16'h01F4, 16'h0FA0);
		u_bus_host_model.bus_write(meas_pkg::ADDR_SCALE, 32'h000FFFFF);
		rchk(meas_pkg::ADDR_SCALE, 32'h000F4240);
		u_bus_host_model.bus_write(meas_pkg::ADDR_SCALE, 32'h00009C40);
		u_bus_host_model.store(32'h00000002);
		repeat (4) @(posedge clock);
		rchk(meas_pkg::ADDR_IA, 32'h000000C8);
		u_bus_host_model.store(32'h00000001);
		repeat (4) @(posedge clock);
		rchk(meas_pkg::ADDR_IA, 32'h00000190);
		rchk(meas_pkg::ADDR_IB, 32'h000000C8);
		rchk(meas_pkg::ADDR_IC, 32'h00000640);
		$display("test currents done");
	endtask

	task automatic test_power;
		drive_ma(16'sh0000, 16'sh0000);
		u_bus_host_model.bus_write(meas_pkg::ADDR_ACT_LIM, 32'h07D0F830);
		u_bus_host_model.bus_write(meas_pkg::ADDR_ACT_PWR, 32'h34BCEC78);
		u_bus_host_model.bus_write(meas_pkg::ADDR_REA_LIM, 32'h07D00190);
		u_bus_host_model.bus_write(meas_pkg::ADDR_REA_PWR, 32'h00DC0000);
		u_bus_host_model.store(32'h00000001);
		repeat (4) @(posedge clock);
		rchk(meas_pkg::ADDR_PVAL, 32'h00000000);
		u_bus_host_model.bus_write(meas_pkg::ADDR_CTRL, 32'h00000001);
		u_bus_host_model.store(32'h00000001);
		repeat (4) @(posedge clock);
		rchk(meas_pkg::ADDR_PVAL, 32'h0000109A);
		drive_ma(-16'sd2000, 16'sd1200);
		repeat (4) @(posedge clock);
		rchk(meas_pkg::ADDR_PVAL, 32'hFFFFEC78);
		rchk(meas_pkg::ADDR_QVAL, 32'h0000006E);
		drive_ma(-16'sd2000, 16'sh0000);
		repeat (4) @(posedge clock);
		rchk(meas_pkg::ADDR_QVAL, 32'h00000000);
		$display("test power done");
	endtask

	task automatic test_energy;
		check({35'h0, ch7_status}, 36'h000000001);
		ch7_pin <= 1'b0;
		u_bus_host_model.bus_write(meas_pkg::ADDR_PWEIGHT, 32'h000001F4);
		u_bus_host_model.bus_write(meas_pkg::ADDR_CTRL, 32'h00000014);
		u_bus_host_model.store(32'h00000001);
		pin_pulse();
		rchk(meas_pkg::ADDR_E_KWH, 32'h00000000);
		u_bus_host_model.bus_write(meas_pkg::ADDR_CTRL, 32'h00000016);
		u_bus_host_model.store(32'h00000001);
		repeat (3) pin_pulse();
		rchk(meas_pkg::ADDR_E_KWH, 32'h0000000F);
		rchk(meas_pkg::ADDR_E_SPLIT, 32'h0000000F);
		ch7_pin <= 1'b1;
		repeat (6) @(posedge clock);
		rchk(meas_pkg::ADDR_E_KWH, 32'h00000014);
		check({34'h0, pulse_led, ch7_status}, 36'h000000000);
		u_bus_host_model.bus_write(meas_pkg::ADDR_CTRL, 32'h0000000A);
		u_bus_host_model.store(32'h00000001);
		repeat (4) @(posedge clock);
		check({35'h0, pulse_led}, 36'h000000001);
		pin_pulse();
		rchk(meas_pkg::ADDR_E_KWH, 32'h00000019);
		u_bus_host_model.bus_write(meas_pkg::ADDR_PWEIGHT, 32'h0001FFFF);
		rchk(meas_pkg::ADDR_PWEIGHT, 32'h000186A0);
		u_bus_host_model.store(32'h00000001);
		pin_pulse();
		rchk(meas_pkg::ADDR_E_KWH, 32'h00000401);
		rchk(meas_pkg::ADDR_E_SPLIT, 32'h00000419);
		$display("test energy done");
	endtask

	// -50.00 MW for about 100 ticks: export lands on 1 kWh whatever the tick phase
	task automatic test_integrate;
		u_bus_host_model.bus_write(meas_pkg::ADDR_CTRL, 32'h00000003);
		u_bus_host_model.store(32'h00000001);
		repeat (1000) @(posedge clock);
		rchk(meas_pkg::ADDR_E_EXP_P, 32'h00000001);
		rchk(meas_pkg::ADDR_E_IMP_P, 32'h00000000);
		rchk(meas_pkg::ADDR_E_IMP_Q, 32'h00000000);
		rchk(meas_pkg::ADDR_E_KWH, 32'h00000000);
		$display("test integrate done");
	endtask

	task automatic test_events;
		u_bus_host_model.write_mask(2, 11'h001);
		event_try(4'h2, 6'h01, 1'b1);
		event_try(4'h2, 6'h02, 1'b0);
		event_try(4'h0, 6'h32, 1'b1);
		event_try(4'hE, 6'h01, 1'b0);
		u_bus_host_model.write_mask(0, 11'h002);
		event_try(4'h0, 6'h01, 1'b0);
		event_try(4'h0, 6'h02, 1'b1);
		u_bus_host_model.write_mask(0, 11'h7FF);
		rchk(meas_pkg::ADDR_MASK0, 32'h0000000F);
		u_bus_host_model.bus_write(meas_pkg::ADDR_MASK0 + 8'h01, 32'h00000FFF);
		rchk(meas_pkg::ADDR_MASK0 + 8'h01, 32'h000007FF);
		$display("test events done");
	endtask

	// main sequence: reset held for 16 cycles, then every test
	initial begin
		rst_n = 1'b0;
		drive_phases(16'h03E8, 16'h03E8, 16'h0000);
		drive_ma(16'sh0000, 16'sh0000);
		ch7_pin = 1'b1;
		evt_valid = 1'b0;
		evt_chan = 4'h0;
		evt_code = 6'h00;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		test_reset_values();
		test_currents();
		test_power();
		test_energy();
		test_integrate();
		test_events();
		end_of_test();
	end

	// watchdog: all tests need far fewer than 20000 cycles
	initial begin
		#160000;
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire
